// *** design/rxa_pkg.sv ***
// Constants for the channel A receive status flags
package rxa_pkg;
  localparam int STAT_W = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int EOF_LIM_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_RX_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RX_DATA_A = 8'h09;
  localparam int BIT_FULL = 0;
  localparam int BIT_EOF = 1;
  localparam int BIT_FLOW = 2;
  localparam int BIT_VALID = 3;
  localparam logic [DATA_W-1:0] ALL_VALID = 8'hff;
  localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;
  localparam logic [EOF_LIM_W-1:0] CNT_RESET = 4'h0;
  localparam logic [EOF_LIM_W-1:0] CNT_STEP = 4'h1;
endpackage

// *** design/rxa_eof_if.sv ***
// Signals between the flag logic and the end-of-frame timer
`timescale 1ns/1ps
`default_nettype none
interface rxa_eof_if;
  import rxa_pkg::*;
  logic bit_tick;
  logic bit_valid;
  logic enable;
  logic [EOF_LIM_W-1:0] limit;
  logic eof;
  modport timer (input bit_tick, input bit_valid, input enable, input limit, output eof);
  modport ctrl (output bit_tick, output bit_valid, output enable, output limit, input eof);
endinterface
`default_nettype wire

// *** design/rxa_eof_timer.sv ***
// End-of-frame timer: counts idle bit times after reception starts
`timescale 1ns/1ps
`default_nettype none
module rxa_eof_timer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  rxa_eof_if.timer eif
);
  import rxa_pkg::*;

  logic armed_reg;
  logic armed_next;
  logic [EOF_LIM_W-1:0] cnt_reg;
  logic [EOF_LIM_W-1:0] cnt_next;
  logic [EOF_LIM_W-1:0] cnt_inc;
  logic eof_reg;
  wire idle_tick;
  wire fire;

  assign cnt_inc = cnt_reg + CNT_STEP;
  assign idle_tick = armed_reg & eif.bit_tick & ~eif.bit_valid;
  // Limit reached with no valid bit since start or last valid bit
  assign fire = idle_tick & (cnt_inc == eif.limit);
  assign armed_next = eif.enable & (eif.bit_valid | (armed_reg & ~fire));
  assign cnt_next = (eif.bit_valid | ~armed_reg) ? CNT_RESET : (idle_tick ? cnt_inc : cnt_reg);
  assign eif.eof = eof_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      armed_reg <= 1'b0;
      cnt_reg <= CNT_RESET;
      eof_reg <= 1'b0;
    end else if (ce_in) begin
      armed_reg <= armed_next;
      cnt_reg <= cnt_next;
      eof_reg <= fire;
    end
  end

  a_eof_fire: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && armed_reg && eif.bit_tick && !eif.bit_valid && cnt_inc == eif.limit |=> eof_reg)
    else $error("eof not raised at limit");
  a_eof_needs_arm: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !armed_reg |=> !eof_reg)
    else $error("eof raised before reception began");
endmodule
`default_nettype wire

// *** design/rxa_status_flags.sv ***
// Channel A receive status flags with read-to-clear status register
// Operation
// - On each data load, valid flag set only if all loaded bits valid
// - Valid flag never drives the event output; status read only
// - Load over unread data sets the flow-violation flag, bit 2
// - Reading empty data register sets the flow-violation flag
// - Status register read clears flow-violation and end-of-frame flags
// - After reception starts, programmed idle bit times raise end-of-frame flag, bit 1
// - Every transfer into the data register sets the full flag, bit 0
// - Transfer on complete byte or on end-of-frame with partial byte
// - Flags other than end-of-frame update regardless of receive enable (timer disarms when off) but hold while clock enable is low; status register is read-only
// - Status reads zero while receive mode is off
`timescale 1ns/1ps
`default_nettype none
module rxa_status_flags (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic rx_enable_in,
  input wire logic bit_tick_in,
  input wire logic bit_valid_in,
  input wire logic byte_done_in,
  input wire logic [rxa_pkg::DATA_W-1:0] load_valid_in,
  input wire logic [rxa_pkg::EOF_LIM_W-1:0] eof_limit_in,
  input wire logic reg_rd_in,
  input wire logic [rxa_pkg::ADDR_W-1:0] reg_addr_in,
  output logic load_out,
  output logic [rxa_pkg::STAT_W-1:0] status_out,
  output logic event_pending_out
);
  import rxa_pkg::*;

  logic valid_reg;
  logic flow_reg;
  logic eof_reg;
  logic full_reg;
  logic unread_reg;
  logic partial_reg;
  logic load_reg;
  logic [STAT_W-1:0] status_reg;
  logic pend_reg;
  logic valid_next;
  logic flow_next;
  logic eof_next;
  logic full_next;
  logic unread_next;
  logic partial_next;
  logic [STAT_W-1:0] status_next;
  wire status_rd;
  wire data_rd;
  wire load;
  wire eof_evt;
  wire flow_set;
  wire all_valid;

  rxa_eof_if eif ();

  assign eif.bit_tick = bit_tick_in;
  assign eif.bit_valid = bit_valid_in;
  assign eif.enable = rx_enable_in;
  assign eif.limit = eof_limit_in;
  assign eof_evt = eif.eof;

  rxa_eof_timer u_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .eif(eif.timer)
  );

  // Register decode; no write path exists
  assign status_rd = reg_rd_in & (reg_addr_in == ADDR_RX_STATUS);
  assign data_rd = reg_rd_in & (reg_addr_in == ADDR_RX_DATA_A);

  // Transfer on full byte or end of frame with partial byte
  assign load = byte_done_in | (eof_evt & partial_reg);
  assign all_valid = (load_valid_in == ALL_VALID);
  assign flow_set = (load & unread_reg) | (data_rd & ~unread_reg);

  assign valid_next = load ? all_valid : valid_reg;
  assign flow_next = flow_set | (flow_reg & ~status_rd);
  assign eof_next = eof_evt | (eof_reg & ~status_rd);
  assign full_next = load | (full_reg & ~data_rd);
  assign unread_next = load | (unread_reg & ~data_rd);
  assign partial_next = bit_valid_in | (partial_reg & ~load);

  // Masked view while receive mode is off
  assign status_next = rx_enable_in
    ? {4'h0, valid_next, flow_next, eof_next, full_next}
    : STAT_RESET;

  assign load_out = load_reg;
  assign status_out = status_reg;
  assign event_pending_out = pend_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      valid_reg <= 1'b0;
      flow_reg <= 1'b0;
      eof_reg <= 1'b0;
      full_reg <= 1'b0;
      unread_reg <= 1'b0;
      partial_reg <= 1'b0;
      load_reg <= 1'b0;
      status_reg <= STAT_RESET;
      pend_reg <= 1'b0;
    end else if (ce_in) begin
      valid_reg <= valid_next;
      flow_reg <= flow_next;
      eof_reg <= eof_next;
      full_reg <= full_next;
      unread_reg <= unread_next;
      partial_reg <= partial_next;
      load_reg <= load;
      status_reg <= status_next;
      pend_reg <= |status_next[BIT_FLOW:BIT_FULL];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_load;
    ce_in && load;
  endsequence
  sequence s_status_read_quiet;
    ce_in && status_rd && !flow_set && !eof_evt;
  endsequence
  sequence s_data_read;
    ce_in && data_rd;
  endsequence
  sequence s_no_load;
    ce_in && !load;
  endsequence
  sequence s_frame_end;
    ce_in && eof_evt;
  endsequence
  sequence s_rx_off;
    ce_in && !rx_enable_in;
  endsequence
  sequence s_rx_on;
    ce_in && rx_enable_in;
  endsequence

  a_valid_all_set: assert property (s_load ##0 all_valid |=> valid_reg)
    else $error("valid flag not set on fully valid load");
  a_valid_part_clr: assert property (s_load ##0 !all_valid |=> !valid_reg)
    else $error("valid flag set on partly valid load");
  a_pending_no_valid: assert property (event_pending_out == |status_out[BIT_FLOW:BIT_FULL])
    else $error("event output does not match flag bits");
  a_overflow_flag: assert property (s_load ##0 unread_reg |=> flow_reg && load_out)
    else $error("overflow not flagged");
  a_underflow_flag: assert property (ce_in && data_rd && !unread_reg |=> flow_reg)
    else $error("underflow not flagged");
  a_read_clears: assert property (s_status_read_quiet |=> !flow_reg && !eof_reg)
    else $error("status read did not clear flags");
  a_full_on_load: assert property (s_load ##0 rx_enable_in |=> full_reg && status_out[BIT_FULL])
    else $error("full flag not set on transfer");
  a_eof_partial_load: assert property (ce_in && eof_evt && partial_reg |-> load ##1 load_out)
    else $error("partial byte not transferred at end of frame");
  a_disabled_zero: assert property (ce_in && !rx_enable_in |=> status_out == STAT_RESET)
    else $error("status not zero outside receive mode");
  a_set_beats_clear: assert property (ce_in && status_rd && eof_evt |=> eof_reg)
    else $error("eof event lost during status read");

  // Valid flag follows transfers only
  a_valid_hold: assert property (s_no_load |=> valid_reg == $past(valid_reg))
    else $error("valid flag changed without a transfer");
  a_valid_quiet: assert property (status_out[BIT_VALID] && status_out[BIT_FLOW:BIT_FULL] == '0
    |-> !event_pending_out)
    else $error("valid flag drives the event output");

  // Flow violation set and clear
  a_overflow_event: assert property (s_load ##0 unread_reg && rx_enable_in |=> event_pending_out)
    else $error("overflow does not raise the event output");
  a_read_no_underflow: assert property (s_data_read ##0 unread_reg && !load && !flow_reg |=> !flow_reg)
    else $error("read of unread data flagged as underflow");
  a_flow_hold: assert property (ce_in && !status_rd && flow_reg |=> flow_reg)
    else $error("flow violation flag lost without a status read");
  a_flow_set_wins: assert property (ce_in && status_rd && flow_set |=> flow_reg)
    else $error("flow violation lost during status read");

  // End of frame
  a_eof_to_status: assert property (s_frame_end ##0 rx_enable_in |=> eof_reg && status_out[BIT_EOF])
    else $error("end of frame not shown in status");
  a_eof_no_event: assert property (ce_in && !eof_evt && !eof_reg |=> !eof_reg)
    else $error("end of frame flag set without an event");
  a_eof_hold: assert property (ce_in && !status_rd && eof_reg |=> eof_reg)
    else $error("end of frame flag lost without a status read");

  // Full flag and transfers
  a_full_cleared: assert property (s_data_read ##0 !load |=> !full_reg && !unread_reg)
    else $error("data read did not empty the data register");
  a_full_set_wins: assert property (s_load ##0 data_rd |=> full_reg)
    else $error("transfer lost during data read");
  a_read_keeps_full: assert property (s_status_read_quiet ##0 full_reg |=> full_reg)
    else $error("status read cleared the full flag");
  a_byte_loads: assert property (ce_in && byte_done_in |=> load_out)
    else $error("complete byte not transferred");
  a_no_stray_load: assert property (s_no_load |=> !load_out)
    else $error("transfer pulse without a cause");
  a_partial_seen: assert property (ce_in && bit_valid_in |=> partial_reg)
    else $error("valid bit not tracked as partial byte");
  a_partial_done: assert property (s_load ##0 !bit_valid_in |=> !partial_reg)
    else $error("partial byte kept after transfer");
  a_eof_empty: assert property (s_frame_end ##0 !partial_reg && !byte_done_in |-> !load)
    else $error("transfer at end of frame with no bits");
  a_load_pulse: assert property (s_load ##1 s_no_load |=> !load_out)
    else $error("transfer pulse longer than one cycle");

  // Enables and masking
  a_kept_while_off: assert property (s_rx_off ##0 load |=> full_reg && unread_reg)
    else $error("flags not updated outside receive mode");
  a_status_mirror: assert property (s_rx_on |=> status_out[BIT_FULL] == full_reg
    && status_out[BIT_FLOW] == flow_reg && status_out[BIT_EOF] == eof_reg
    && status_out[BIT_VALID] == valid_reg)
    else $error("status does not show the flags");
  a_event_off: assert property (s_rx_off |=> !event_pending_out)
    else $error("event output raised outside receive mode");

  // Clock enable low freezes every output
  a_hold_outputs: assert property (!ce_in |=> $stable(status_out) && $stable(load_out)
    && $stable(event_pending_out))
    else $error("outputs changed while clock enable low");
endmodule
`default_nettype wire

// *** verification/rxa_host_model.sv ***
// Host model issuing one-cycle register reads
`timescale 1ns/1ps
`default_nettype none
module rxa_host_model (
  input wire logic clk_in,
  output logic reg_rd_out,
  output logic [rxa_pkg::ADDR_W-1:0] reg_addr_out
);
  import rxa_pkg::*;
  initial begin
    reg_rd_out = 1'b0;
    reg_addr_out = '0;
  end
  // Read strobe for one cycle, address scrambled once released, then one idle cycle
  task automatic rd(input logic [ADDR_W-1:0] a);
    reg_rd_out = 1'b1;
    reg_addr_out = a;
    @(posedge clk_in);
    #1;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    @(posedge clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// *** verification/rxa_status_flags_tb_top.sv ***
// Bench for the channel A receive status flags
`timescale 1ns/1ps
`default_nettype none
module rxa_status_flags_tb_top;
  import rxa_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic rx_en = 1'b1;
  logic ce = 1'b1;
  logic tick = 1'b0;
  logic bval = 1'b0;
  logic bdone = 1'b0;
  logic [DATA_W-1:0] mask = '0;
  logic [EOF_LIM_W-1:0] lim = 4'h2;
  logic rd;
  logic [ADDR_W-1:0] addr;
  logic load;
  logic evt;
  logic [STAT_W-1:0] stat;
  logic [DATA_W-1:0] m;
  int n_errors = 0;
  int num_checks = 0;
  always #25 clk_in = ~clk_in;
  rxa_status_flags dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .rx_enable_in(rx_en),
    .bit_tick_in(tick), .bit_valid_in(bval), .byte_done_in(bdone), .load_valid_in(mask),
    .eof_limit_in(lim), .reg_rd_in(rd), .reg_addr_in(addr), .load_out(load), .status_out(stat),
    .event_pending_out(evt));
  rxa_host_model host (.clk_in(clk_in), .reg_rd_out(rd), .reg_addr_out(addr));
  function automatic logic [7:0] exp_valid(input logic [DATA_W-1:0] v);
    return (v === ALL_VALID) ? 8'h01 : 8'h00;
  endfunction
  task automatic cyc();
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic ld(input logic [DATA_W-1:0] v);
    mask = v;
    bdone = 1'b1;
    cyc();
    bdone = 1'b0;
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
  initial begin
    void'($urandom(32'h0d30));
    repeat (5) cyc();
    rst_n_in = 1'b1;
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? ALL_VALID : DATA_W'($urandom);
      ld(m);
      chk("load", 8'h01, {7'h0, load});
      chk("valid", exp_valid(m), {7'h0, stat[BIT_VALID]});
      chk("full", 8'h01, {7'h0, stat[BIT_FULL]});
      host.rd(ADDR_RX_DATA_A);
      chk("event", 8'h00, {7'h0, evt});
    end
    ld(ALL_VALID);
    cyc();
    host.rd(ADDR_RX_DATA_A);
    host.rd(ADDR_RX_DATA_A);
    chk("underflow", 8'h0c, stat);
    host.rd(ADDR_RX_STATUS);
    chk("clear", 8'h08, stat);
    ld(8'h0f);
    cyc();
    ld(8'h0f);
    chk("overflow", 8'h05, stat);
    cyc();
    fork
      host.rd(ADDR_RX_STATUS);
      ld(8'h0f);
    join
    chk("set wins", 8'h05, stat);
    rx_en = 1'b0;
    cyc();
    chk("rx off", 8'h00, stat);
    rx_en = 1'b1;
    cyc();
    chk("kept", 8'h05, stat);
    host.rd(ADDR_RX_STATUS);
    host.rd(ADDR_RX_DATA_A);
    chk("idle", 8'h00, stat);
    ce = 1'b0;
    ld(8'h0f);
    chk("frozen status", 8'h00, stat);
    chk("frozen load", 8'h00, {7'h0, load});
    ce = 1'b1;
    bval = 1'b1;
    tick = 1'b1;
    cyc();
    bval = 1'b0;
    repeat (2) cyc();
    tick = 1'b0;
    repeat (3) cyc();
    chk("eof", 8'h03, stat);
    rst_n_in = 1'b0;
    cyc();
    chk("reset status", 8'h00, stat);
    chk("reset event", 8'h00, {7'h0, evt});
    rst_n_in = 1'b1;
    ld(ALL_VALID);
    chk("restart", 8'h09, stat);
    chk("restart event", 8'h01, {7'h0, evt});
    test_done();
  end
endmodule
`default_nettype wire
